/* File: verilog/uarx_pkg.sv */
`default_nettype none
package uarx_pkg;
    // Register bus
    localparam int          ADDR_W       = 2;
    localparam int          DATA_W       = 16;
    localparam logic [1:0]  ADDR_DATA    = 2'h0;
    localparam logic [1:0]  ADDR_STATUS  = 2'h1;
    localparam logic [1:0]  ADDR_CTRL    = 2'h2;
    localparam logic [1:0]  ADDR_BAUD    = 2'h3;
    localparam int          STAT_RXC     = 0;
    localparam int          STAT_FERR    = 1;

    // Frame geometry
    localparam int          FRAME_MAX    = 10;
    localparam logic [3:0]  FRAME_MIN_B  = 4'h5;
    localparam logic [3:0]  FRAME_MAX_B  = 4'hA;
    localparam logic [4:0]  SPB_NORMAL   = 5'h10;
    localparam logic [4:0]  SPB_DOUBLE   = 5'h08;
    localparam logic [4:0]  SF_NORMAL    = 5'h08;
    localparam logic [4:0]  SF_DOUBLE    = 5'h04;

    // Receive buffer
    localparam int          RX_BUF_DEPTH = 2;
    localparam int          RX_CNT_W     = $clog2(RX_BUF_DEPTH + 1);

    // Reset values
    localparam logic [5:0]  CTRL_RESET   = 6'h20;
    localparam logic [15:0] BAUD_RESET   = 16'h0004;

    typedef struct packed {
        logic [3:0] frame_bits;
        logic       double_speed_select;
        logic       receiver_enable_bit;
    } uarx_ctrl_t;

    typedef struct packed {
        logic       frame_error_flag;
        logic [9:0] data;
    } uarx_frame_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b11
    } uarx_state_t;
endpackage : uarx_pkg
`default_nettype wire

/* File: verilog/uarx_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module uarx_tick #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // Control
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    // Sample enable
    output var  logic         tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         tick_r;
    logic         tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!en) begin
            cnt_nxt = '0;
        end else if (cnt_r >= div) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : uarx_tick
`default_nettype wire

/* File: verilog/uarx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module uarx_fifo #(
    parameter int W     = 11,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          resetn,
    input  wire logic          flush,
    // Fill side
    input  wire logic          in_valid,
    output var  logic          in_ready,
    input  wire logic [W-1:0]  in_data,
    // Drain side
    output var  logic          out_valid,
    input  wire logic          out_ready,
    output var  logic [W-1:0]  out_data,
    output var  logic [CW-1:0] count
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] wp_nxt;
    logic [PW-1:0] rp_r;
    logic [PW-1:0] rp_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          do_wr;
    logic          do_rd;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : bump

    assign in_ready  = (cnt_r != CW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign count     = cnt_r;
    assign do_wr     = in_valid && in_ready && !flush;
    assign do_rd     = out_valid && out_ready && !flush;

    always_comb begin
        wp_nxt  = do_wr ? bump(wp_r) : wp_r;
        rp_nxt  = do_rd ? bump(rp_r) : rp_r;
        cnt_nxt = cnt_r + CW'(do_wr) - CW'(do_rd);
        if (flush) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; emptiness is tracked by the count
    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule : uarx_fifo
`default_nettype wire

/* File: verilog/uarx_rx.sv */
// Overview of operation
// - Disabling receiver flushes all unread characters
// - Sample at 16x, or 8x in double speed
// - Idle-to-low edge starts detection, sample one
// - Start validated on samples 8-10 or 4-6
// - Majority high start samples means noise, rewait
// - Valid start locks phase, every frame again
// - Sixteen or eight sample states per bit
// - Data and parity bits by three-sample majority
// - Recover through first stop bit, ignore others
// - Stop bit voted; zero sets frame error
// - New start edge right after stop voting
// - Double-speed bit one selects 8x sampling
// - Frames of five to ten bits supported
// - Receive-complete flag mirrors buffer not empty
// - Two-entry queue, each data read advances
`timescale 1ns/1ps
`default_nettype none
module uarx_rx #(
    parameter int BAUD_W = 16
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    // Register port
    input  wire logic [uarx_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [uarx_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [uarx_pkg::DATA_W-1:0] reg_rdata,
    // Serial line and status
    input  wire logic                        serial_rx_pin,
    output var  logic                        rx_complete_flag
);
    uarx_pkg::uarx_ctrl_t           ctrl_r;
    uarx_pkg::uarx_ctrl_t           ctrl_nxt;
    logic [BAUD_W-1:0]              baud_r;
    logic [BAUD_W-1:0]              baud_nxt;
    logic [uarx_pkg::DATA_W-1:0]    rdata_r;
    logic [uarx_pkg::DATA_W-1:0]    rdata_nxt;
    logic                           rxc_r;
    logic                           rx_s1_r;
    logic                           rx_s2_r;
    uarx_pkg::uarx_state_t          state_r;
    uarx_pkg::uarx_state_t          state_nxt;
    logic [4:0]                     ph_r;
    logic [4:0]                     ph_nxt;
    logic [3:0]                     bit_r;
    logic [3:0]                     bit_nxt;
    logic [1:0]                     votes_r;
    logic [1:0]                     votes_nxt;
    logic                           prev_r;
    logic                           prev_nxt;
    logic [9:0]                     shreg_r;
    logic [9:0]                     shreg_nxt;
    logic                           tick;
    logic [4:0]                     spb;
    logic [4:0]                     sf2;
    logic [3:0]                     fb;
    logic                           majv;
    logic                           push_v;
    logic                           push_rdy;
    uarx_pkg::uarx_frame_t          push_d;
    logic                           buf_valid;
    logic                           pop;
    uarx_pkg::uarx_frame_t          head;
    logic [uarx_pkg::RX_CNT_W-1:0]  buf_count;

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    // Serial input synchroniser
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= serial_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    uarx_tick #(
        .W    (BAUD_W)
    ) u_tick (
        .mclk   (mclk),
        .resetn (resetn),
        .en     (ctrl_r.receiver_enable_bit),
        .div    (baud_r),
        .tick   (tick)
    );

    // Geometry for the selected speed and frame size
    always_comb begin
        spb = ctrl_r.double_speed_select ? uarx_pkg::SPB_DOUBLE : uarx_pkg::SPB_NORMAL;
        sf2 = (ctrl_r.double_speed_select ? uarx_pkg::SF_DOUBLE
                                          : uarx_pkg::SF_NORMAL) + 5'h02;
        fb  = ctrl_r.frame_bits;
        if (fb < uarx_pkg::FRAME_MIN_B) begin
            fb = uarx_pkg::FRAME_MIN_B;
        end else if (fb > uarx_pkg::FRAME_MAX_B) begin
            fb = uarx_pkg::FRAME_MAX_B;
        end
        majv = maj3({votes_r, rx_s2_r});
    end

    // Clock and data recovery
    always_comb begin
        state_nxt = state_r;
        ph_nxt    = ph_r;
        bit_nxt   = bit_r;
        votes_nxt = votes_r;
        prev_nxt  = prev_r;
        shreg_nxt = shreg_r;
        push_v    = 1'b0;
        push_d    = '{frame_error_flag: !majv,
                      data: 10'(shreg_r >> (4'hA - fb))};
        if (!ctrl_r.receiver_enable_bit) begin
            // Disabling is immediate; a frame in flight is lost
            state_nxt = uarx_pkg::RX_IDLE;
            prev_nxt  = 1'b1;
            ph_nxt    = '0;
        end else if (tick) begin
            votes_nxt = {votes_r[0], rx_s2_r};
            case (state_r)
                uarx_pkg::RX_IDLE: begin
                    prev_nxt = rx_s2_r;
                    if (prev_r && !rx_s2_r) begin
                        state_nxt = uarx_pkg::RX_START;
                        ph_nxt    = 5'h01;
                    end
                end
                uarx_pkg::RX_START: begin
                    if (ph_r == sf2 && majv) begin
                        state_nxt = uarx_pkg::RX_IDLE;
                        prev_nxt  = rx_s2_r;
                    end else if (ph_r >= spb) begin
                        state_nxt = uarx_pkg::RX_BITS;
                        ph_nxt    = 5'h01;
                        bit_nxt   = '0;
                    end else begin
                        ph_nxt = ph_r + 5'h01;
                    end
                end
                uarx_pkg::RX_BITS: begin
                    ph_nxt = (ph_r >= spb) ? 5'h01 : ph_r + 5'h01;
                    if (ph_r == sf2) begin
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r < fb) begin
                            shreg_nxt = {majv, shreg_r[9:1]};
                        end else begin
                            // Further stop bits are simply idle line
                            push_v    = 1'b1;
                            state_nxt = uarx_pkg::RX_IDLE;
                            prev_nxt  = majv;
                        end
                    end
                end
                default: begin
                    state_nxt = uarx_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= uarx_pkg::RX_IDLE;
            ph_r    <= '0;
            bit_r   <= '0;
            votes_r <= 2'h3;
            prev_r  <= 1'b1;
            shreg_r <= '0;
        end else begin
            state_r <= state_nxt;
            ph_r    <= ph_nxt;
            bit_r   <= bit_nxt;
            votes_r <= votes_nxt;
            prev_r  <= prev_nxt;
            shreg_r <= shreg_nxt;
        end
    end

    // Receive queue; a full queue drops the new frame, no overrun flag kept
    uarx_fifo #(
        .W     ($bits(uarx_pkg::uarx_frame_t)),
        .DEPTH (uarx_pkg::RX_BUF_DEPTH),
        .CW    (uarx_pkg::RX_CNT_W)
    ) u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .flush     (!ctrl_r.receiver_enable_bit),
        .in_valid  (push_v),
        .in_ready  (push_rdy),
        .in_data   (push_d),
        .out_valid (buf_valid),
        .out_ready (pop),
        .out_data  (head),
        .count     (buf_count)
    );

    // Register access
    always_comb begin
        ctrl_nxt  = ctrl_r;
        baud_nxt  = baud_r;
        rdata_nxt = '0;
        pop       = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                uarx_pkg::ADDR_CTRL: ctrl_nxt = reg_wdata[5:0];
                uarx_pkg::ADDR_BAUD: baud_nxt = reg_wdata[BAUD_W-1:0];
                default:             ctrl_nxt = ctrl_r;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                uarx_pkg::ADDR_DATA: begin
                    // An empty queue reads as zero, never as a stale or unwritten slot
                    rdata_nxt = buf_valid ? {6'h00, head.data} : '0;
                    pop       = buf_valid;
                end
                uarx_pkg::ADDR_STATUS: begin
                    rdata_nxt[uarx_pkg::STAT_RXC]  = buf_valid;
                    rdata_nxt[uarx_pkg::STAT_FERR] = buf_valid && head.frame_error_flag;
                end
                uarx_pkg::ADDR_CTRL: rdata_nxt = {10'h000, ctrl_r};
                uarx_pkg::ADDR_BAUD: rdata_nxt[BAUD_W-1:0] = baud_r;
                default:             rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_r  <= uarx_pkg::CTRL_RESET;
            baud_r  <= BAUD_W'(uarx_pkg::BAUD_RESET);
            rdata_r <= '0;
            rxc_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            baud_r  <= baud_nxt;
            rdata_r <= rdata_nxt;
            rxc_r   <= buf_valid;
        end
    end

    assign reg_rdata        = rdata_r;
    assign rx_complete_flag = rxc_r;

    property p_flush;
        @(posedge mclk) disable iff (!resetn)
        !ctrl_r.receiver_enable_bit |=> !buf_valid ##1 !rx_complete_flag;
    endproperty
    a_flush: assert property (p_flush) else $error("buffer not flushed on disable");

    property p_start_edge;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && tick && state_r == uarx_pkg::RX_IDLE && prev_r && !rx_s2_r)
        |=> (state_r == uarx_pkg::RX_START && ph_r == 5'h01);
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start edge missed");

    property p_noise;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && tick && state_r == uarx_pkg::RX_START && ph_r == sf2 && majv)
        |=> state_r == uarx_pkg::RX_IDLE;
    endproperty
    a_noise: assert property (p_noise) else $error("noise start accepted");

    property p_valid_start;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && tick && state_r == uarx_pkg::RX_START && ph_r == sf2 && !majv)
        |=> (state_r == uarx_pkg::RX_START && ph_r == $past(ph_r) + 5'h01);
    endproperty
    a_valid_start: assert property (p_valid_start) else $error("valid start rejected");

    property p_wrap;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && tick && state_r == uarx_pkg::RX_BITS && ph_r >= spb)
        |=> ph_r == 5'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("bit phase did not wrap");

    property p_vote;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && tick && state_r == uarx_pkg::RX_BITS && ph_r == sf2
         && bit_r < fb) |=> shreg_r[9] == $past(maj3({votes_r, rx_s2_r}));
    endproperty
    a_vote: assert property (p_vote) else $error("bit vote wrong");

    property p_stop;
        @(posedge mclk) disable iff (!resetn)
        push_v |-> (push_d.frame_error_flag == !maj3({votes_r, rx_s2_r}))
                   ##1 (state_r == uarx_pkg::RX_IDLE && prev_r == !$past(push_d.frame_error_flag));
    endproperty
    a_stop: assert property (p_stop) else $error("stop handling wrong");

    property p_advance;
        @(posedge mclk) disable iff (!resetn)
        (ctrl_r.receiver_enable_bit && reg_rd && reg_addr == uarx_pkg::ADDR_DATA && !push_v
         && buf_count == uarx_pkg::RX_CNT_W'(1)) |=> !buf_valid ##1 !rx_complete_flag;
    endproperty
    a_advance: assert property (p_advance) else $error("read did not advance queue");
endmodule : uarx_rx
`default_nettype wire

/* File: bench/uarx_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uarx_line_model (
    // Clock
    input  wire logic mclk,
    // Serial line
    output var  logic line
);
    // The line idles high between frames, as a pulled-up wire would
    initial line = 1'b1;

    // Start bit, nbits LSB first, then the stop level held stop_len cycles
    task automatic send(input logic [9:0] d, input int nbits, input logic stop_v,
                        input int bit_len, input int stop_len);
        @(posedge mclk) line <= 1'b0;
        repeat (bit_len) @(posedge mclk);
        for (int i = 0; i < nbits; i++) begin
            line <= d[i];
            repeat (bit_len) @(posedge mclk);
        end
        line <= stop_v;
        repeat (stop_len) @(posedge mclk);
        line <= 1'b1;
    endtask : send

    // A short low pulse that a receiver must reject
    task automatic glitch(input int len);
        @(posedge mclk) line <= 1'b0;
        repeat (len) @(posedge mclk);
        line <= 1'b1;
    endtask : glitch
endmodule : uarx_line_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk;
    logic        resetn;
    logic [1:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        serial_line;
    logic        rx_complete_flag;
    logic [15:0] rv;
    int          bad_count;
    int          check_count;
    int          bit_len;

    always #50 mclk = ~mclk;

    uarx_rx #(.BAUD_W(16)) uut (
        .mclk             (mclk),
        .resetn           (resetn),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .serial_rx_pin    (serial_line),
        .rx_complete_flag (rx_complete_flag)
    );

    uarx_line_model far (
        .mclk (mclk),
        .line (serial_line)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rdchk(input logic [1:0] a, input logic [15:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(rv, exp, what);
    endtask : rdchk

    task automatic cfg(input logic en, input logic dbl, input int n);
        wr(uarx_pkg::ADDR_CTRL, {10'h000, 4'(n), dbl, en});
        bit_len = dbl ? 16 : 32;
    endtask : cfg

    task automatic frame(input logic [9:0] d, input int n, input logic stop_v);
        far.send(d, n, stop_v, bit_len, bit_len);
        repeat (bit_len) @(posedge mclk);
    endtask : frame

    task automatic wait_flag(input logic exp);
        int k;
        k = 0;
        while (rx_complete_flag !== exp && k < 200) begin
            @(posedge mclk);
            k++;
        end
        if (rx_complete_flag !== exp) begin
            bad_count++;
            $display("unexpected at %0t: receive flag wait ran out", $time);
            tally_and_finish();
        end
    endtask : wait_flag

    task automatic t_reset;
        rdchk(uarx_pkg::ADDR_CTRL, {10'h000, uarx_pkg::CTRL_RESET}, "ctrl reset");
        rdchk(uarx_pkg::ADDR_BAUD, uarx_pkg::BAUD_RESET, "baud reset");
        rdchk(uarx_pkg::ADDR_STATUS, 16'h0000, "status reset");
        wr(uarx_pkg::ADDR_STATUS, 16'hFFFF);
        rdchk(uarx_pkg::ADDR_STATUS, 16'h0000, "status not writable");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0000, "empty data read");
        wr(uarx_pkg::ADDR_BAUD, 16'h0001);
        rdchk(uarx_pkg::ADDR_BAUD, 16'h0001, "baud write");
        $display("test reset done");
    endtask : t_reset

    task automatic t_sizes;
        logic [9:0] v;
        for (int dbl = 0; dbl < 2; dbl++) begin
            for (int n = 5; n <= 10; n++) begin
                cfg(1'b1, dbl[0], n);
                v = 10'h2B5 & ((10'h001 << n) - 10'h001);
                frame(v, n, 1'b1);
                wait_flag(1'b1);
                rdchk(uarx_pkg::ADDR_STATUS, 16'h0001, "status after frame");
                rdchk(uarx_pkg::ADDR_DATA, {6'h00, v}, "frame data");
                wait_flag(1'b0);
            end
        end
        $display("test frame sizes done");
    endtask : t_sizes

    task automatic t_stop;
        cfg(1'b1, 1'b0, 8);
        frame(10'h03C, 8, 1'b0);
        wait_flag(1'b1);
        rdchk(uarx_pkg::ADDR_STATUS, 16'h0003, "frame error");
        rdchk(uarx_pkg::ADDR_DATA, 16'h003C, "data with bad stop");
        far.send(10'h081, 8, 1'b1, bit_len, 2 * bit_len);
        wait_flag(1'b1);
        rdchk(uarx_pkg::ADDR_STATUS, 16'h0001, "second stop ignored");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0081, "two stop bits");
        // Stop bit cut short just past the voting samples
        far.send(10'h07E, 8, 1'b1, bit_len, 26);
        frame(10'h042, 8, 1'b1);
        rdchk(uarx_pkg::ADDR_DATA, 16'h007E, "short stop frame");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0042, "frame after short stop");
        $display("test stop bit done");
    endtask : t_stop

    task automatic t_noise;
        cfg(1'b1, 1'b0, 8);
        far.glitch(14);
        repeat (80) @(posedge mclk);
        chk({15'h0000, rx_complete_flag}, 16'h0000, "noise rejected");
        frame(10'h055, 8, 1'b1);
        wait_flag(1'b1);
        rdchk(uarx_pkg::ADDR_DATA, 16'h0055, "frame after noise");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0000, "only one frame");
        $display("test noise done");
    endtask : t_noise

    task automatic t_queue;
        logic [15:0] exp [2];
        int          k;
        exp = '{16'h0011, 16'h0022};
        frame(10'h011, 8, 1'b1);
        frame(10'h022, 8, 1'b1);
        frame(10'h033, 8, 1'b1);
        k = 0;
        // Software flush: keep reading while the flag is up
        while (rx_complete_flag === 1'b1 && k < 4) begin
            rdchk(uarx_pkg::ADDR_DATA, (k < 2) ? exp[k] : 16'hFFFF, "queue order");
            @(posedge mclk);
            // The flag lags the queue by a cycle; look once it has settled
            #1;
            k++;
        end
        chk(16'(k), 16'h0002, "queue depth");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0000, "drained");
        $display("test queue done");
    endtask : t_queue

    task automatic t_disable;
        frame(10'h0A1, 8, 1'b1);
        frame(10'h0A2, 8, 1'b1);
        chk({15'h0000, rx_complete_flag}, 16'h0001, "filled");
        cfg(1'b0, 1'b0, 8);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0000, rx_complete_flag}, 16'h0000, "flushed on disable");
        cfg(1'b1, 1'b0, 8);
        rdchk(uarx_pkg::ADDR_STATUS, 16'h0000, "status after flush");
        rdchk(uarx_pkg::ADDR_DATA, 16'h0000, "data after flush");
        $display("test disable done");
    endtask : t_disable

    initial begin
        mclk        = 1'b0;
        resetn      = 1'b0;
        reg_addr    = 2'h0;
        reg_wdata   = 16'h0000;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        bad_count   = 0;
        check_count = 0;
        bit_len     = 32;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_sizes();
        t_stop();
        t_noise();
        t_queue();
        t_disable();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
